// >>> hdl/epwm_consts.vh
// Purpose: constants for the enhanced pwm shutdown and steering block
// Assumes: apb byte addresses, 32-bit data, registers in low byte
// Notes: offsets are local choices
`ifndef EPWM_CONSTS_VH
`define EPWM_CONSTS_VH
`define EPWM_OFF_TMRSEL 12'h000
`define EPWM_OFF_ASCTL 12'h004
`define EPWM_OFF_RSDLY 12'h008
`define EPWM_OFF_STEER 12'h00C
`define EPWM_OFF_MODE 12'h010
`define EPWM_OFF_IRQ_STAT 12'h014
`define EPWM_OFF_IRQ_MASK 12'h018
`define EPWM_OFF_TSYNC 12'h01C
`define EPWM_RST_TMRSEL 8'h00
`define EPWM_RST_ASCTL 8'h00
`define EPWM_RST_RSDLY 8'h00
`define EPWM_RST_STEER 8'h01
`define EPWM_RST_MODE 8'h00
`define EPWM_AS_EVT 7
`define EPWM_RS_EN 7
`define EPWM_ST_SYNC 4
`define EPWM_ST_MASK 8'h1F
`define EPWM_TSEL_T2 2'b00
`define EPWM_TSEL_T4 2'b01
`define EPWM_TSEL_T6 2'b10
`define EPWM_PSS_LOW 2'b00
`define EPWM_PSS_HIGH 2'b01
`define EPWM_IRQ_SHDN 0
`define EPWM_IRQ_RESUME 1
`endif

// >>> hdl/epwm_ctrl.v
// Purpose: auto-shutdown, active delay, steering and timer choice
// Assumes: single clock; pwm waveform and period starts come from outside
// Notes: apb slave, zero wait states, pslverr on unmapped address
//   only channel 1 is steered and delayed; the other channels only
//   export their timer choice
//
// Operation
// - two-bit selector picks timer 2, 4 or 6
// - shutdown source sets status, outputs shutdown state
// - source codes 001 to 011 select comparators, 000 selects none
// - codes 1xx add low external pin
// - pair a/c shutdown low, high or float
// - pair b/d shutdown low, high or float
// - restart enable clears status when source gone
// - seven-bit delay before output goes active
// - synced comparator waits for timer 1 tick
// - sync bit: steering updates at period start
// - no sync: steering updates next cycle
// - steering enables route waveform with polarity
// - steering only in pwm single-output mode
// - steering register top three bits read zero
// - mode low bits set pair polarities
`timescale 1ns/1ps
`include "epwm_consts.vh"
module epwm_ctrl (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// pwm inputs
	input wire [2:0] timer_period_start,
	input wire [2:0] timer_pwm_raw,
	input wire comp1_out,
	input wire comp2_out,
	input wire ext_int_pin,
	input wire timer1_tick,
	// per-channel selected timer for channels 1..4
	output reg [7:0] chan_timer_onehot,
	// pins
	output reg pwm_out_a,
	output reg pwm_out_b,
	output reg pwm_out_c,
	output reg pwm_out_d,
	output reg [3:0] pwm_oe,
	output reg [3:0] pin_port_ctrl,
	// interrupt
	output reg irq
);
	reg [7:0] pwm_timer_select;
	reg [7:0] auto_shutdown_control;
	reg [7:0] restart_and_delay_control;
	reg [7:0] output_steering_control;
	reg [7:0] mode_control;
	reg [1:0] comparator_out_sync;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg [3:0] steer_active;
	reg [6:0] delay_cnt;
	reg pwm_delayed;
	reg raw_q;
	reg comp1_q;
	reg comp2_q;
	reg drive_hold;
	reg shutdown_prev;

	wire [3:0] channel_mode_sel = mode_control[3:0];
	wire [1:0] output_config_sel = mode_control[7:6];
	wire [2:0] shutdown_source_sel = auto_shutdown_control[6:4];
	wire [1:0] shutdown_state_ac = auto_shutdown_control[3:2];
	wire [1:0] shutdown_state_bd = auto_shutdown_control[1:0];
	wire shutdown_event_status = auto_shutdown_control[`EPWM_AS_EVT];
	wire auto_restart_enable = restart_and_delay_control[`EPWM_RS_EN];
	wire [6:0] active_delay_count = restart_and_delay_control[6:0];
	wire steer_update_sync = output_steering_control[`EPWM_ST_SYNC];

	// timer 2/4/6 feeds the steered channel (channel 1)
	function [2:0] tsel_onehot;
		input [1:0] sel;
		begin
			case (sel)
			`EPWM_TSEL_T2: tsel_onehot = 3'b001;
			`EPWM_TSEL_T4: tsel_onehot = 3'b010;
			`EPWM_TSEL_T6: tsel_onehot = 3'b100;
			default: tsel_onehot = 3'b000;
			endcase
		end
	endfunction

	// pair level in shutdown: bit0 = level, bit1 = enable
	function [1:0] pss_drive;
		input [1:0] st;
		begin
			case (st)
			`EPWM_PSS_LOW: pss_drive = 2'b10;
			`EPWM_PSS_HIGH: pss_drive = 2'b11;
			default: pss_drive = 2'b00;
			endcase
		end
	endfunction

	// pin level: the shutdown level wins over the waveform
	function pin_level;
		input shut;
		input shut_level;
		input wave;
		begin
			pin_level = shut ? shut_level : wave;
		end
	endfunction

	// pin drive: steered, and not floated by the shutdown state
	function pin_drive;
		input steer_en;
		input shut;
		input shut_drive;
		begin
			pin_drive = steer_en & (~shut | shut_drive);
		end
	endfunction

	wire pwm_mode = (channel_mode_sel[3:2] == 2'b11);
	wire [2:0] sel1 = tsel_onehot(pwm_timer_select[1:0]);
	wire period_start = |(sel1 & timer_period_start);
	wire pwm_raw = |(sel1 & timer_pwm_raw);

	// comparators optionally wait for a timer 1 tick
	wire c1_eff = comparator_out_sync[0] ? comp1_q : comp1_out;
	wire c2_eff = comparator_out_sync[1] ? comp2_q : comp2_out;
	reg src_hit;
	always @* begin
		case (shutdown_source_sel)
		3'b000: src_hit = 1'b0;
		3'b001: src_hit = c1_eff;
		3'b010: src_hit = c2_eff;
		3'b011: src_hit = c1_eff | c2_eff;
		3'b100: src_hit = ~ext_int_pin;
		3'b101: src_hit = ~ext_int_pin | c1_eff;
		3'b110: src_hit = ~ext_int_pin | c2_eff;
		3'b111: src_hit = ~ext_int_pin | c1_eff | c2_eff;
		default: src_hit = 1'b0;
		endcase
	end

	// register select, shared by every write strobe
	function reg_hit;
		input [11:0] addr;
		input [11:0] offset;
		begin
			reg_hit = (addr == offset);
		end
	endfunction

	// anything outside the register map is refused with pslverr
	function addr_mapped;
		input [11:0] addr;
		begin
			case (addr)
			`EPWM_OFF_TMRSEL, `EPWM_OFF_ASCTL, `EPWM_OFF_RSDLY,
			`EPWM_OFF_STEER, `EPWM_OFF_MODE, `EPWM_OFF_IRQ_STAT,
			`EPWM_OFF_IRQ_MASK, `EPWM_OFF_TSYNC: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
			endcase
		end
	endfunction

	// read mux; unmapped offsets read zero
	function [7:0] read_byte;
		input [11:0] addr;
		begin
			case (addr)
			`EPWM_OFF_TMRSEL: read_byte = pwm_timer_select;
			`EPWM_OFF_ASCTL: read_byte = auto_shutdown_control;
			`EPWM_OFF_RSDLY: read_byte = restart_and_delay_control;
			`EPWM_OFF_STEER: read_byte = output_steering_control;
			`EPWM_OFF_MODE: read_byte = mode_control;
			`EPWM_OFF_IRQ_STAT: read_byte = {6'h00, irq_status};
			`EPWM_OFF_IRQ_MASK: read_byte = {6'h00, irq_mask};
			`EPWM_OFF_TSYNC: read_byte = {6'h00, comparator_out_sync};
			default: read_byte = 8'h00;
			endcase
		end
	endfunction

	// writes land at the access edge, the one where pready is high
	wire wr = psel & penable & pwrite;
	wire as_wr = wr & reg_hit(paddr, `EPWM_OFF_ASCTL);
	wire [1:0] irq_w1c = (wr & reg_hit(paddr, `EPWM_OFF_IRQ_STAT)) ?
		pwdata[1:0] : 2'b00;
	// the shutdown source wins over a software clear
	wire next_evt = src_hit | (auto_restart_enable ? 1'b0 :
		(as_wr ? pwdata[`EPWM_AS_EVT] : shutdown_event_status));
	wire resume_evt = shutdown_prev & ~next_evt;

	// shutdown status follows next_evt; the other fields are plain
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			auto_shutdown_control <= `EPWM_RST_ASCTL;
			shutdown_prev <= 1'b0;
		end else begin
			shutdown_prev <= next_evt;
			auto_shutdown_control[`EPWM_AS_EVT] <= next_evt;
			if (as_wr) begin
				auto_shutdown_control[6:0] <= pwdata[6:0];
			end
		end
	end

	// timer selection for all four channels
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_timer_select <= `EPWM_RST_TMRSEL;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_TMRSEL)) begin
			pwm_timer_select <= pwdata[7:0];
		end
	end

	// restart enable and active delay count
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			restart_and_delay_control <= `EPWM_RST_RSDLY;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_RSDLY)) begin
			restart_and_delay_control <= pwdata[7:0];
		end
	end

	// steering enables; the top three bits never store
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			output_steering_control <= `EPWM_RST_STEER;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_STEER)) begin
			output_steering_control <= pwdata[7:0] & `EPWM_ST_MASK;
		end
	end

	// channel mode and output configuration
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_control <= `EPWM_RST_MODE;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_MODE)) begin
			mode_control <= pwdata[7:0];
		end
	end

	// comparator synchronisation enables
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			comparator_out_sync <= 2'b00;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_TSYNC)) begin
			comparator_out_sync <= pwdata[1:0];
		end
	end

	// interrupt mask
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask <= 2'b00;
		end else if (wr && reg_hit(paddr, `EPWM_OFF_IRQ_MASK)) begin
			irq_mask <= pwdata[1:0];
		end
	end

	// set wins over the write-one clear in the same cycle
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status <= 2'b00;
		end else begin
			irq_status[`EPWM_IRQ_SHDN] <= (next_evt & ~shutdown_prev) |
				(irq_status[`EPWM_IRQ_SHDN] &
				~irq_w1c[`EPWM_IRQ_SHDN]);
			irq_status[`EPWM_IRQ_RESUME] <= resume_evt |
				(irq_status[`EPWM_IRQ_RESUME] &
				~irq_w1c[`EPWM_IRQ_RESUME]);
		end
	end

	// apb answer: zero wait states, data latched in the setup cycle
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_mapped(paddr);
			if (psel & ~penable) begin
				prdata <= {24'h00_0000, read_byte(paddr)};
			end
		end
	end

	// comparator sync, active delay, steering latch, drive hold
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			comp1_q <= 1'b0;
			comp2_q <= 1'b0;
			raw_q <= 1'b0;
			delay_cnt <= 7'h00;
			pwm_delayed <= 1'b0;
			steer_active <= 4'h1;
			drive_hold <= 1'b0;
		end else begin
			if (timer1_tick) begin
				comp1_q <= comp1_out;
				comp2_q <= comp2_out;
			end
			raw_q <= pwm_raw;
			if (!pwm_raw) begin
				pwm_delayed <= 1'b0;
				delay_cnt <= 7'h00;
			end else if (!raw_q) begin
				delay_cnt <= active_delay_count;
				pwm_delayed <= (active_delay_count == 7'h00);
			end else if (delay_cnt != 7'h00) begin
				delay_cnt <= delay_cnt - 7'h01;
				pwm_delayed <= (delay_cnt == 7'h01);
			end
			if (!steer_update_sync || period_start)
				steer_active <= output_steering_control[3:0];
			// limitation: a shutdown that clears between period starts
			// keeps the pins in shutdown until the next period
			if (next_evt)
				drive_hold <= 1'b1;
			else if (period_start)
				drive_hold <= 1'b0;
		end
	end

	wire steer_ok = pwm_mode & (output_config_sel == 2'b00);
	wire [3:0] en = steer_ok ? steer_active : 4'h0;
	wire lvl_ac = pwm_delayed ^ channel_mode_sel[1];
	wire lvl_bd = pwm_delayed ^ channel_mode_sel[0];
	wire [1:0] sd_ac = pss_drive(shutdown_state_ac);
	wire [1:0] sd_bd = pss_drive(shutdown_state_bd);
	wire sd = shutdown_event_status | drive_hold;

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
			pwm_out_c <= 1'b0;
			pwm_out_d <= 1'b0;
			pwm_oe <= 4'h0;
			pin_port_ctrl <= 4'hF;
			irq <= 1'b0;
			chan_timer_onehot <= 8'h00;
		end else begin
			chan_timer_onehot <= {pwm_timer_select[7:6],
				pwm_timer_select[5:4], pwm_timer_select[3:2],
				pwm_timer_select[1:0]};
			pin_port_ctrl <= ~en;
			pwm_out_a <= pin_level(sd, sd_ac[0], lvl_ac);
			pwm_out_c <= pin_level(sd, sd_ac[0], lvl_ac);
			pwm_out_b <= pin_level(sd, sd_bd[0], lvl_bd);
			pwm_out_d <= pin_level(sd, sd_bd[0], lvl_bd);
			pwm_oe[0] <= pin_drive(en[0], sd, sd_ac[1]);
			pwm_oe[2] <= pin_drive(en[2], sd, sd_ac[1]);
			pwm_oe[1] <= pin_drive(en[1], sd, sd_bd[1]);
			pwm_oe[3] <= pin_drive(en[3], sd, sd_bd[1]);
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule // epwm_ctrl

// >>> verif/epwm_asserts.sv
// Purpose: port checks for epwm_ctrl
// Assumes: zero wait apb, local offsets
// Notes: shadows shutdown fields from bus writes
`timescale 1ns/1ps
module epwm_asserts (
	// clock, reset, apb
	input wire clock,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// pins
	input wire ext_int_pin,
	input wire [7:0] chan_timer_onehot,
	input wire pwm_out_a,
	input wire [3:0] pwm_oe,
	input wire [3:0] pin_port_ctrl
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite;
	reg [2:0] src;
	reg [1:0] pss;
	reg [7:0] tsel;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			src <= 3'h0;
			pss <= 2'h0;
			tsel <= 8'h00;
		end else if (wr && paddr == 12'h004) begin
			src <= pwdata[6:4];
			pss <= pwdata[3:2];
		end else if (wr && paddr == 12'h000) begin
			tsel <= pwdata[7:0];
		end
	end
	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_unmapped: assert property (pready && paddr > 12'h01C |-> pslverr)
		else $error("unmapped not refused");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 0)
		else $error("refused read not zero");
	a_steer_top: assert property (
		acc && !pwrite && paddr == 12'h00C |-> prdata[31:5] == 0)
		else $error("steer top bits set");
	a_tsel_copy: assert property (
		wr && paddr == 12'h000 |-> ##2 chan_timer_onehot == tsel)
		else $error("timer select not copied");
	a_pin_owner: assert property ((pwm_oe & pin_port_ctrl) == 0)
		else $error("pin driven and released");
	a_ext_shdn: assert property (
		(src[2] && !ext_int_pin) [*3] |-> (pss[1] ? !pwm_oe[0]
		: (pin_port_ctrl[0] || pwm_out_a == pss[0])))
		else $error("pin a not in shutdown state");
	c_refused: cover property (acc && pslverr);
	c_ext: cover property (src[2] && !ext_int_pin);
	c_steer: cover property ($fell(pin_port_ctrl[1]));
endmodule // epwm_asserts

// >>> verif/epwm_switch_model.sv
// Purpose: power switch gate drivers on the pins
// Assumes: pins pulled low when not driven
// Notes: released pin keeps the switch off
`timescale 1ns/1ps
module epwm_switch_model (
	// pins
	input wire [3:0] pin,
	input wire [3:0] oe,
	// gates
	output wire [3:0] gate
);
	assign gate = pin & oe;
endmodule // epwm_switch_model

// >>> verif/epwm_ctrl_test.sv
// Purpose: self-checking bench for epwm_ctrl
// Assumes: delay count 0, channel 1 on timer 2
// Notes: reads checked by a monitor from a queue
`timescale 1ns/1ps
module epwm_ctrl_test;
	reg clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	reg [2:0] tps = 0, raw = 0;
	reg c1 = 0, c2 = 0, ext = 1, t1 = 0;
	wire [31:0] prdata;
	wire pready, pslverr, irq, a, b, c, d;
	wire [7:0] sel;
	wire [3:0] oe, ppc, gate;
	reg [7:0] v;
	int n_errors = 0, n_compared = 0;
	logic [31:0] q[$];
	always #5 clock = ~clock;
	epwm_ctrl dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_period_start(tps),
		.timer_pwm_raw(raw), .comp1_out(c1), .comp2_out(c2),
		.ext_int_pin(ext), .timer1_tick(t1), .chan_timer_onehot(sel),
		.pwm_out_a(a), .pwm_out_b(b), .pwm_out_c(c), .pwm_out_d(d),
		.pwm_oe(oe), .pin_port_ctrl(ppc), .irq(irq));
	epwm_switch_model sw (.pin({d, c, b, a}), .oe(oe), .gate(gate));
	task automatic chk(input string nm, input [31:0] s, input [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task bus(input w, input [11:0] ad, input [31:0] dt);
		if (!clock)
			@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clock);
		penable <= 1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask
	task wr(input [11:0] ad, input [31:0] dt);
		bus(1, ad, dt);
	endtask
	task rd(input [11:0] ad, input [31:0] e);
		q.push_back(e);
		bus(0, ad, 0);
	endtask
	task per;
		if (!clock)
			@(posedge clock);
		tps <= 3'h1;
		@(posedge clock);
		tps <= 3'h0;
		repeat (3) @(posedge clock);
	endtask
	task conclude;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock)
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			chk("prdata", prdata, q.pop_front());
			chk("pslverr", pslverr, paddr > 12'h01C);
		end
	initial begin
		#100000;
		n_errors++;
		conclude;
	end
	initial begin
		v = $urandom(65);
		repeat (8) @(posedge clock);
		sys_rst <= 0;
		@(posedge clock);
		for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'(i == 3));
		repeat (3) begin
			v = $urandom;
			wr(12'h000, v);
			rd(12'h000, v);
			chk("sel", sel, v);
		end
		wr(12'h000, 0);
		wr(12'h00C, 32'h0000_00FF);
		rd(12'h00C, 32'h0000_001F);
		rd(12'h020, 0);
		$display("registers done");
		wr(12'h00C, 32'h0000_000F);
		wr(12'h010, 32'h0000_000C);
		raw <= 3'h1;
		per;
		chk("high", {d, c, b, a}, 4'hF);
		wr(12'h010, 32'h0000_000F);
		per;
		chk("low", {d, c, b, a}, 4'h0);
		wr(12'h00C, 32'h0000_0005);
		@(posedge clock);
		@(negedge clock);
		chk("port", ppc, 4'hA);
		wr(12'h00C, 32'h0000_001F);
		repeat (2) @(negedge clock);
		chk("held", ppc, 4'hA);
		per;
		chk("synced", ppc, 4'h0);
		$display("steering done");
		wr(12'h010, 32'h0000_000C);
		wr(12'h018, 32'h0000_0001);
		wr(12'h004, 32'h0000_0044);
		ext <= 0;
		repeat (4) @(posedge clock);
		chk("shut", gate, 4'h5);
		chk("irq", irq, 1);
		ext <= 1;
		per;
		rd(12'h004, 32'h0000_00C4);
		wr(12'h004, 32'h0000_0044);
		repeat (2) @(negedge clock);
		chk("still", gate, 4'h5);
		per;
		chk("resumed", gate, 4'hF);
		wr(12'h014, 32'h0000_0003);
		@(posedge clock);
		chk("irq clear", irq, 0);
		wr(12'h018, 0);
		wr(12'h008, 32'h0000_0080);
		wr(12'h004, 32'h0000_0018);
		c1 <= 1;
		repeat (4) @(posedge clock);
		chk("float", oe, 4'hA);
		chk("masked", irq, 0);
		c1 <= 0;
		per;
		rd(12'h004, 32'h0000_0018);
		rd(12'h014, 32'h0000_0003);
		chk("restart", gate, 4'hF);
		wr(12'h01C, 32'h0000_0001);
		c1 <= 1;
		repeat (4) @(posedge clock);
		chk("sync wait", oe, 4'hF);
		t1 <= 1;
		@(posedge clock);
		t1 <= 0;
		repeat (3) @(posedge clock);
		chk("sync shut", oe, 4'hA);
		$display("shutdown done");
		conclude;
	end
endmodule // epwm_ctrl_test
bind epwm_ctrl epwm_asserts chk_i (.clock(clock), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ext_int_pin(ext_int_pin),
	.chan_timer_onehot(chan_timer_onehot), .pwm_out_a(pwm_out_a),
	.pwm_oe(pwm_oe), .pin_port_ctrl(pin_port_ctrl));
